//--- core/ssr_status.sv
// Supply status reporting: operating and fault groups, each with live
// condition, enable mask and clear-on-read change events.
// Assumes status pins arrive asynchronously and commands come on clk.
`timescale 1ns/1ps

module ssr_status
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,

	// Command port
	input wire logic cmdValid,
	input wire ssr_cmd_t cmd,
	output logic cmdReady,

	// Answer port
	output ssr_resp_t resp,

	// Status pins
	input wire ssr_op_raw_t opRaw,
	input wire ssr_flt_raw_t fltRaw,

	// Live condition registers
	output logic [OP_W-1:0] opConditionLive,
	output logic [FLT_W-1:0] faultConditionLive
);

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	ssr_regs_t st_ff;
	ssr_regs_t nxt_st;

	logic take;
	logic opClear;
	logic fltClear;
	logic [OP_W-1:0] opLive;
	logic [FLT_W-1:0] fltLive;
	logic [OP_W-1:0] opChange;
	logic [FLT_W-1:0] fltChange;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		take = 1'b0;
		opClear = 1'b0;
		fltClear = 1'b0;
		opLive = '0;
		fltLive = '0;
		opChange = '0;
		fltChange = '0;

		// Pin synchronisers
		nxt_st.opSyncA = opRaw;
		nxt_st.opSyncB = st_ff.opSyncA;
		nxt_st.fltSyncA = fltRaw;
		nxt_st.fltSyncB = st_ff.fltSyncA;

		opLive[OP_BIT_CURRENT] = st_ff.opSyncB.currentMode;
		opLive[OP_BIT_RELAY] = st_ff.opSyncB.relayClosed;
		opLive[OP_BIT_VOLTAGE] = st_ff.opSyncB.voltageMode;

		fltLive[FLT_BIT_POWER] = st_ff.fltSyncB.inputPowerLost;
		fltLive[FLT_BIT_LOAD] = st_ff.fltSyncB.loadExcessFault;
		fltLive[FLT_BIT_CONTACT] = st_ff.fltSyncB.contactFault;
		fltLive[FLT_BIT_THERMAL] = st_ff.fltSyncB.thermalFault;
		fltLive[FLT_BIT_CURRENT] = st_ff.fltSyncB.currentFault;
		fltLive[FLT_BIT_VOLTAGE] = st_ff.fltSyncB.outputVoltageFault;

		take = cmdValid && st_ff.cmdReady;

		// Command sequencer
		case (st_ff.state)
			ST_IDLE: begin
				nxt_st.resp.valid = 1'b0;
				if (take) begin
					nxt_st.state = ST_ANSWER;
					nxt_st.cmdReady = 1'b0;
					nxt_st.resp.valid = 1'b1;
					nxt_st.resp.error = 1'b0;
					nxt_st.resp.data = '0;
					case (cmd.code)
						CMD_OP_COND_RD: begin
							nxt_st.resp.data = FLT_W'(st_ff.opCond);
						end
						CMD_OP_MASK_WR: begin
							nxt_st.opMask = cmd.data[OP_W-1:0] & OP_USED;
						end
						CMD_OP_MASK_RD: begin
							nxt_st.resp.data = FLT_W'(st_ff.opMask);
						end
						CMD_OP_EVENT_RD: begin
							nxt_st.resp.data = FLT_W'(st_ff.opEvent);
							opClear = 1'b1;
						end
						CMD_PRESET: begin
							nxt_st.opMask = OP_RESET;
							nxt_st.fltMask = FLT_RESET;
						end
						CMD_FLT_EVENT_RD: begin
							nxt_st.resp.data = st_ff.fltEvent;
							fltClear = 1'b1;
						end
						CMD_FLT_COND_RD: begin
							nxt_st.resp.data = st_ff.fltCond;
						end
						CMD_FLT_MASK_WR: begin
							nxt_st.fltMask = cmd.data & FLT_USED;
						end
						CMD_FLT_MASK_RD: begin
							nxt_st.resp.data = st_ff.fltMask;
						end
						default: begin
							nxt_st.resp.error = 1'b1;
						end
					endcase
				end
			end
			ST_ANSWER: begin
				// Answer stands one cycle
				nxt_st.state = ST_IDLE;
				nxt_st.cmdReady = 1'b1;
				nxt_st.resp.valid = 1'b0;
			end
			default: begin
				nxt_st.state = ST_IDLE;
				nxt_st.cmdReady = 1'b1;
				nxt_st.resp.valid = 1'b0;
			end
		endcase

		nxt_st.opCond = opLive & nxt_st.opMask;
		nxt_st.fltCond = fltLive & nxt_st.fltMask;

		opChange = nxt_st.opCond ^ st_ff.opCond;
		fltChange = nxt_st.fltCond ^ st_ff.fltCond;

		if (opClear) begin
			nxt_st.opEvent = opChange;
		end else begin
			nxt_st.opEvent = st_ff.opEvent | opChange;
		end

		if (fltClear) begin
			nxt_st.fltEvent = fltChange;
		end else begin
			nxt_st.fltEvent = st_ff.fltEvent | fltChange;
		end
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= REGS_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign cmdReady = st_ff.cmdReady;
	assign resp = st_ff.resp;
	assign opConditionLive = st_ff.opCond;
	assign faultConditionLive = st_ff.fltCond;

endmodule : ssr_status

//--- core/ssr_pkg.sv
// Constants, codes and carrier types of the supply status reporting block.
// Assumes one clock domain and a command source that speaks the command codes below.
package ssr_pkg;

	// -----------------------------------------------------------------
	// Widths
	// -----------------------------------------------------------------
	localparam int OP_W = 11;
	localparam int FLT_W = 12;
	localparam int CODE_W = 4;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int OP_BIT_CURRENT = 10;
	localparam int OP_BIT_RELAY = 9;
	localparam int OP_BIT_VOLTAGE = 8;
	localparam int FLT_BIT_POWER = 11;
	localparam int FLT_BIT_LOAD = 10;
	localparam int FLT_BIT_CONTACT = 9;
	localparam int FLT_BIT_THERMAL = 3;
	localparam int FLT_BIT_CURRENT = 1;
	localparam int FLT_BIT_VOLTAGE = 0;

	// -----------------------------------------------------------------
	// Implemented bits and reset values
	// -----------------------------------------------------------------
	localparam logic [OP_W-1:0] OP_USED = 11'h700;
	localparam logic [FLT_W-1:0] FLT_USED = 12'hE0B;
	localparam logic [OP_W-1:0] OP_RESET = 11'h000;
	localparam logic [FLT_W-1:0] FLT_RESET = 12'h000;

	// -----------------------------------------------------------------
	// Commands
	// -----------------------------------------------------------------
	typedef enum logic [CODE_W-1:0] {
		CMD_OP_COND_RD = 4'h1,
		CMD_OP_MASK_WR = 4'h2,
		CMD_OP_MASK_RD = 4'h3,
		CMD_OP_EVENT_RD = 4'h4,
		CMD_PRESET = 4'h5,
		CMD_FLT_EVENT_RD = 4'h6,
		CMD_FLT_COND_RD = 4'h7,
		CMD_FLT_MASK_WR = 4'h8,
		CMD_FLT_MASK_RD = 4'h9
	} ssr_code_t;

	// -----------------------------------------------------------------
	// Sequencer states
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_ANSWER = 2'h2
	} ssr_state_t;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic [FLT_W-1:0] data;
	} ssr_cmd_t;

	typedef struct packed {
		logic valid;
		logic error;
		logic [FLT_W-1:0] data;
	} ssr_resp_t;

	typedef struct packed {
		logic currentMode;
		logic relayClosed;
		logic voltageMode;
	} ssr_op_raw_t;

	typedef struct packed {
		logic inputPowerLost;
		logic loadExcessFault;
		logic contactFault;
		logic thermalFault;
		logic currentFault;
		logic outputVoltageFault;
	} ssr_flt_raw_t;

	typedef struct packed {
		ssr_state_t state;
		logic cmdReady;
		ssr_resp_t resp;
		ssr_op_raw_t opSyncA;
		ssr_op_raw_t opSyncB;
		ssr_flt_raw_t fltSyncA;
		ssr_flt_raw_t fltSyncB;
		logic [OP_W-1:0] opMask;
		logic [OP_W-1:0] opCond;
		logic [OP_W-1:0] opEvent;
		logic [FLT_W-1:0] fltMask;
		logic [FLT_W-1:0] fltCond;
		logic [FLT_W-1:0] fltEvent;
	} ssr_regs_t;

	localparam ssr_regs_t REGS_RESET = '{
		state: ST_IDLE,
		cmdReady: 1'b1,
		resp: '0,
		opSyncA: '0,
		opSyncB: '0,
		fltSyncA: '0,
		fltSyncB: '0,
		opMask: OP_RESET,
		opCond: OP_RESET,
		opEvent: OP_RESET,
		fltMask: FLT_RESET,
		fltCond: FLT_RESET,
		fltEvent: FLT_RESET
	};

endpackage : ssr_pkg

//--- tb/ssr_status_assertions.sv
// Port checker of the status block.
// Sees only the block's ports; bound at the foot.
`timescale 1ns/1ps
module ssr_status_assertions
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports
	input wire logic cmdValid,
	input wire ssr_cmd_t cmd,
	input wire logic cmdReady,
	input wire ssr_resp_t resp,
	input wire ssr_op_raw_t opRaw,
	input wire ssr_flt_raw_t fltRaw,
	input wire logic [OP_W-1:0] opConditionLive,
	input wire logic [FLT_W-1:0] faultConditionLive
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_take(ssr_code_t c);
		cmdValid && cmdReady && cmd.code == c;
	endsequence
	a_op_unused: assert property ((opConditionLive & ~OP_USED) == '0)
		else $error("unused operating bit set");
	a_flt_unused: assert property ((faultConditionLive & ~FLT_USED) == '0)
		else $error("unused fault bit set");
	a_preset_clear: assert property (s_take(CMD_PRESET) |=>
		opConditionLive == '0 && faultConditionLive == '0) else $error("preset left bits");
	a_relay_hidden: assert property (s_take(CMD_OP_MASK_WR) ##0 !cmd.data[OP_BIT_RELAY]
		|=> !opConditionLive[OP_BIT_RELAY] [*2]) else $error("relay shown");
	a_cur_live: assert property (opConditionLive[OP_BIT_CURRENT]
		|-> $past(opRaw.currentMode, 3)) else $error("current mode not live");
	a_pwr_live: assert property (faultConditionLive[FLT_BIT_POWER]
		|-> $past(fltRaw.inputPowerLost, 3)) else $error("power loss not live");
	a_opcond_read: assert property (s_take(CMD_OP_COND_RD) ##1 $stable(opConditionLive)
		|-> resp.valid && resp.data == {1'b0, opConditionLive}) else $error("op read");
	a_fltcond_read: assert property (s_take(CMD_FLT_COND_RD) ##1 $stable(faultConditionLive)
		|-> resp.valid && resp.data == faultConditionLive) else $error("fault read");
endmodule : ssr_status_assertions

bind ssr_status ssr_status_assertions u_chk (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
	.cmd(cmd), .cmdReady(cmdReady), .resp(resp), .opRaw(opRaw), .fltRaw(fltRaw),
	.opConditionLive(opConditionLive), .faultConditionLive(faultConditionLive));

//--- tb/ssr_ctrl_model.sv
// Remote controller model: sends one command word, collects its answer.
// Assumes the block answers one cycle after taking a command.
`timescale 1ns/1ps
module ssr_ctrl_model
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Command and answer
	output logic cmdValid,
	output ssr_cmd_t cmd,
	input wire logic cmdReady,
	input wire ssr_resp_t resp
);
	initial begin
		cmdValid = 1'b0;
		cmd = '0;
	end
	task automatic issue(input ssr_code_t c, input logic [FLT_W-1:0] d, output ssr_resp_t r);
		int n;
		n = 0;
		cmdValid <= 1'b1;
		cmd <= '{code: c, data: d};
		do begin
			@(posedge clk);
			n++;
		end while (cmdReady !== 1'b1 && n < 20);
		cmdValid <= 1'b0;
		cmd <= ~cmd;
		@(posedge clk);
		r = resp;
	endtask : issue
endmodule : ssr_ctrl_model

//--- tb/tb.sv
// Bench of the status block: command sequences with expected answers.
// Assumes the checker is bound to the block.
`timescale 1ns/1ps
module tb;
	import ssr_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	ssr_op_raw_t opRaw = '0;
	ssr_flt_raw_t fltRaw = '0;
	logic cmdValid;
	logic cmdReady;
	ssr_cmd_t cmd;
	ssr_resp_t resp;
	logic [OP_W-1:0] opLive;
	logic [FLT_W-1:0] fltLive;
	int errors = 0;
	int cmpCount = 0;
	int cycles = 0;
	int pos [6] = '{11, 10, 9, 3, 1, 0};
	always #2 clk = ~clk;
	ssr_status u_dut (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .resp(resp), .opRaw(opRaw), .fltRaw(fltRaw),
		.opConditionLive(opLive), .faultConditionLive(fltLive));
	ssr_ctrl_model u_ctl (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .resp(resp));
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, cmpCount);
		if (errors == 0 && cmpCount > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [FLT_W+1:0] g, input logic [FLT_W+1:0] e);
		cmpCount++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// One command with its expected answer data
	task automatic io(input ssr_code_t c, input logic [FLT_W-1:0] d, input logic [FLT_W-1:0] e);
		ssr_resp_t r;
		u_ctl.issue(c, d, r);
		chk({r.valid, r.error, r.data}, {2'b10, e});
	endtask : io
	// Unknown code: answered with error set and no data
	task automatic bad(input logic [CODE_W-1:0] c);
		ssr_resp_t r;
		u_ctl.issue(ssr_code_t'(c), '0, r);
		chk({r.valid, r.error, r.data}, {2'b11, 12'h000});
	endtask : bad
	// Live condition outputs, looked at mid-cycle where they are settled
	task automatic live(input logic [OP_W-1:0] o, input logic [FLT_W-1:0] f);
		@(negedge clk);
		cmpCount++;
		if ({opLive, fltLive} !== {o, f}) begin
			errors++;
			$display("ERROR %0t live got %h %h exp %h %h", $time, opLive, fltLive, o, f);
		end
		@(posedge clk);
	endtask : live
	// Pins take three edges to show
	task automatic pins(input ssr_op_raw_t o, input ssr_flt_raw_t f);
		opRaw <= o;
		fltRaw <= f;
		repeat (3) @(posedge clk);
	endtask : pins
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			end_of_test;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		io(CMD_OP_MASK_RD, '0, '0);
		io(CMD_FLT_MASK_RD, '0, '0);
		io(CMD_OP_EVENT_RD, '0, '0);
		io(CMD_OP_MASK_WR, 12'hFFF, '0);
		io(CMD_OP_MASK_RD, '0, 12'h700);
		io(CMD_FLT_MASK_WR, 12'hFFF, '0);
		io(CMD_FLT_MASK_RD, '0, 12'hE0B);
		pins(3'h3, '0);
		live(11'h300, 12'h000);
		io(CMD_OP_EVENT_RD, '0, 12'h300);
		io(CMD_OP_EVENT_RD, '0, '0);
		pins(3'h6, '0);
		io(CMD_OP_COND_RD, '0, 12'h600);
		io(CMD_OP_EVENT_RD, '0, 12'h500);
		io(CMD_OP_MASK_WR, 12'h500, '0);
		io(CMD_OP_COND_RD, '0, 12'h400);
		io(CMD_OP_EVENT_RD, '0, 12'h200);
		pins(3'h4, '0);
		io(CMD_OP_EVENT_RD, '0, '0);
		// Voltage mode rises on the very edge that takes the clearing read
		opRaw <= 3'h5;
		repeat (2) @(posedge clk);
		io(CMD_OP_EVENT_RD, '0, '0);
		io(CMD_OP_EVENT_RD, '0, 12'h100);
		for (int i = 0; i < 6; i++) begin
			pins(3'h4, 6'h20 >> i);
			io(CMD_FLT_COND_RD, '0, 12'h001 << pos[i]);
		end
		io(CMD_FLT_EVENT_RD, '0, 12'hE0B);
		io(CMD_FLT_EVENT_RD, '0, '0);
		pins(3'h7, 6'h3F);
		live(11'h500, 12'hE0B);
		io(CMD_FLT_COND_RD, '0, 12'hE0B);
		io(CMD_PRESET, '0, '0);
		live(11'h000, 12'h000);
		io(CMD_OP_COND_RD, '0, '0);
		io(CMD_FLT_COND_RD, '0, '0);
		io(CMD_OP_MASK_WR, 12'hFFF, '0);
		io(CMD_FLT_MASK_WR, 12'hFFF, '0);
		live(11'h700, 12'hE0B);
		bad(4'hF);
		io(CMD_OP_MASK_RD, '0, 12'h700);
		// Second reset with masks and events loaded
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		io(CMD_OP_MASK_RD, '0, '0);
		io(CMD_FLT_MASK_RD, '0, '0);
		io(CMD_OP_EVENT_RD, '0, '0);
		io(CMD_FLT_EVENT_RD, '0, '0);
		live(11'h000, 12'h000);
		end_of_test;
	end
endmodule : tb
